// File: core/pwm_cfg.svh
// Register map, field positions and reset values of the timer/PWM block
// Function
// R01 - Period matches feed 4-bit postscaler, sets flag
// R02 - Flag latched; interrupt only when enabled
// R03 - Postscale code N divides by N+1
// R04 - Unscaled match is modulator time base
// R05 - Sleep freezes count and period registers
// R06 - Prescale codes 00/01/10 divide 1/4/16
// R07 - Four 10-bit channels share one period
// R08 - Outputs set when count restarts period
// R09 - Clear output when time base equals duty
// R10 - Duty at or beyond period never clears
// R11 - Duty double buffered, loaded on match
// R12 - Software writes both duty halves before match
// R13 - Polarity bit inverts channel output
// R14 - After match: clear count, set, load
// R15 - Period is (period+1)*4*prescale clocks
// R16 - Time base is count joined with subcount
// R17 - Postscaler never touches modulator timing
// R18 - Duty registers writable at any time
// R19 - Sleep holds pin level; resume from state
// R20 - Output enable clear releases the pin
// R21 - Reset clears registers, pins become inputs; the period register resets to all ones instead
// R22 - Width beyond period leaves pin unchanged
// R23 - Match zeroes count; counts up per tick
// R24 - Reset clears count, period to all ones
// R25 - Count/control writes and reset clear scalers
// R26 - Timer counts only while on bit set
// R27 - Channel updates only while enabled; readback
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
// Byte offsets
`define OFF_CTL     8'h00
`define OFF_CNT     8'h04
`define OFF_PER     8'h08
`define OFF_FLAG    8'h0C
`define OFF_IE      8'h10
`define CH_REGION   2'h1
`define SUB_CON     2'h0
`define SUB_DCH     2'h1
`define SUB_DCL     2'h2
// Timer control fields
`define CTL_POST_HI 6
`define CTL_POST_LO 3
`define CTL_ON      2
`define CTL_PS_HI   1
`define CTL_PS_LO   0
`define FLAG_BIT    0
// Channel control fields
`define CON_EN      7
`define CON_OE      6
`define CON_VAL     5
`define CON_POL     4
`define DCL_HI      7
`define DCL_LO      6
// Prescaler terminal counts in system clocks (4 per instruction clock)
`define PS_CODE_1   2'h0
`define PS_CODE_4   2'h1
`define PS_LAST_1   6'h03
`define PS_LAST_4   6'h0F
`define PS_LAST_16  6'h3F
// Reset values
`define RST_CNT     8'h00
`define RST_PER     8'hFF
`define RST_CTL     7'h00
`endif

// File: core/pwm_pkg.sv
// Types shared by the timer/PWM block
package pwm_pkg;
  typedef struct packed {
    logic [3:0] post;
    logic       on;
    logic [1:0] presc;
  } tb_ctl_type;
  typedef struct packed {
    logic enable;
    logic oe;
    logic pol;
  } chan_cfg_type;
endpackage

// File: core/timebase_postscaler_pwm.sv
// Period timer with pre/postscaler and four 10-bit PWM channels
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module timebase_postscaler_pwm #(
  parameter int NCH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Processor sleep
  input  wire logic             sleep_i,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic [3:0]       wb_sel_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Interrupt and time base
  output logic                  irq_o,
  output logic                  match_o,
  // Channel outputs
  output logic      [NCH-1:0]   pwm_o,
  output logic      [NCH-1:0]   pin_o,
  output logic      [NCH-1:0]   pin_oe_o
);
  import pwm_pkg::*;

  function automatic logic [5:0] presc_last(input logic [1:0] ps);
    if (ps == `PS_CODE_1) begin
      return `PS_LAST_1;
    end else if (ps == `PS_CODE_4) begin
      return `PS_LAST_4;
    end
    return `PS_LAST_16;
  endfunction

  // Two time base bits that count prescaled system clocks
  function automatic logic [1:0] tb_low(input logic [5:0] pc,
                                        input logic [1:0] ps);
    if (ps == `PS_CODE_1) begin
      return pc[1:0];
    end else if (ps == `PS_CODE_4) begin
      return pc[3:2];
    end
    return pc[5:4];
  endfunction

  tb_ctl_type        ctl_q;
  logic [7:0]        cnt_q;
  logic [7:0]        per_q;
  logic [5:0]        pc_q;
  logic [3:0]        post_q;
  logic              flag_q;
  logic              ie_q;
  logic              ack_q;
  logic [31:0]       dat_q;
  chan_cfg_type      cfg_q  [NCH];
  logic [7:0]        dch_q  [NCH];
  logic [1:0]        dcl_q  [NCH];
  logic [9:0]        buf_q  [NCH];
  logic [NCH-1:0]    out_q;

  // Bus decode
  logic        req;
  logic        wr;
  logic [7:0]  wd;
  logic        sel_ctl;
  logic        sel_cnt;
  logic        sel_per;
  logic        sel_flag;
  logic        sel_ie;
  logic        sel_ch;
  logic [1:0]  ch_idx;
  logic [1:0]  ch_sub;
  logic        wr_ctl;
  logic        wr_cnt;
  logic        wr_per;
  logic        wr_flag;
  logic        wr_ie;

  assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign wd       = wb_dat_i[7:0];
  assign sel_ctl  = (wb_adr_i == `OFF_CTL);
  assign sel_cnt  = (wb_adr_i == `OFF_CNT);
  assign sel_per  = (wb_adr_i == `OFF_PER);
  assign sel_flag = (wb_adr_i == `OFF_FLAG);
  assign sel_ie   = (wb_adr_i == `OFF_IE);
  assign sel_ch   = (wb_adr_i[7:6] == `CH_REGION);
  assign ch_idx   = wb_adr_i[5:4];
  assign ch_sub   = wb_adr_i[3:2];
  assign wr_ctl   = wr & sel_ctl;
  assign wr_cnt   = wr & sel_cnt;
  assign wr_per   = wr & sel_per;
  assign wr_flag  = wr & sel_flag;
  assign wr_ie    = wr & sel_ie;

  // Timer core
  logic        run;
  logic        tick;
  logic        match;
  logic        post_hit;
  logic [9:0]  tb;
  logic [10:0] lim;
  logic        flag_d;
  logic [5:0]  pc_nx;
  logic [7:0]  cnt_nx;
  logic [9:0]  tb_nx;

  assign run      = ctl_q.on & ~sleep_i;                       // R05 R26
  assign tick     = run & (pc_q == presc_last(ctl_q.presc));   // R06 R15
  assign match    = tick & (cnt_q == per_q);
  assign post_hit = match & (post_q == ctl_q.post);            // R01 R03
  assign tb       = {cnt_q, tb_low(pc_q, ctl_q.presc)};        // R16
  assign lim      = {({1'b0, per_q} + 9'h001), 2'b00};
  // Hardware set wins over a software clear in the same cycle
  assign flag_d   = post_hit | (wr_flag ? wd[`FLAG_BIT] : flag_q);
  // Time base one cycle ahead, so a channel falls as the duty is reached
  assign pc_nx    = tick ? 6'h00 : pc_q + 6'h01;
  assign cnt_nx   = match ? `RST_CNT : cnt_q + {7'h00, tick};
  assign tb_nx    = {cnt_nx, tb_low(pc_nx, ctl_q.presc)};       // R09

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= `RST_CTL;
      per_q <= `RST_PER;                                       // R24
      ie_q  <= 1'b0;
    end else begin
      if (wr_ctl) begin
        ctl_q <= wd[`CTL_POST_HI:`CTL_PS_LO];
      end
      if (wr_per) begin
        per_q <= wd;
      end
      if (wr_ie) begin
        ie_q <= wd[`FLAG_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || wr_ctl || wr_cnt) begin
      pc_q   <= '0;                                            // R25
      post_q <= '0;
    end else if (run) begin
      pc_q <= tick ? 6'h00 : pc_q + 6'h01;
      if (match) begin
        post_q <= post_hit ? 4'h0 : post_q + 4'h1;             // R01
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= `RST_CNT;                                       // R24
    end else if (wr_cnt) begin
      cnt_q <= wd;
    end else if (tick) begin
      cnt_q <= match ? `RST_CNT : cnt_q + 8'h01;               // R23
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;                                        // R02
    end
  end

  assign irq_o   = flag_q & ie_q;                              // R02
  assign match_o = match;                                      // R04

  // Channels
  logic [NCH-1:0] wr_con;
  logic [NCH-1:0] wr_dch;
  logic [NCH-1:0] wr_dcl;
  logic [NCH-1:0] full;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] val;

  for (genvar g = 0; g < NCH; g++) begin : g_ch // R07
    assign wr_con[g] = wr & sel_ch & (ch_idx == 2'(g)) & (ch_sub == `SUB_CON);
    assign wr_dch[g] = wr & sel_ch & (ch_idx == 2'(g)) & (ch_sub == `SUB_DCH);
    assign wr_dcl[g] = wr & sel_ch & (ch_idx == 2'(g)) & (ch_sub == `SUB_DCL);
    assign full[g]   = ({1'b0, buf_q[g]} >= lim);              // R10 R22
    assign hit[g]    = run & (tb_nx == buf_q[g]) & ~full[g]; // R09
    assign val[g]    = out_q[g] ^ cfg_q[g].pol;                // R13
    assign pwm_o[g]  = val[g];                                 // R20
    assign pin_o[g]  = val[g];
    assign pin_oe_o[g] = cfg_q[g].oe;                          // R20 R21
  end

  // Duty writes are taken at any time, only the buffers are timed
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NCH; i++) begin
      if (rst_i) begin
        cfg_q[i] <= '0;                                        // R21
        dch_q[i] <= '0;
        dcl_q[i] <= '0;
        buf_q[i] <= '0;
      end else begin
        if (wr_con[i]) begin
          cfg_q[i] <= {wd[`CON_EN], wd[`CON_OE], wd[`CON_POL]};
        end
        if (wr_dch[i]) begin
          dch_q[i] <= wd;                                      // R18
        end
        if (wr_dcl[i]) begin
          dcl_q[i] <= wd[`DCL_HI:`DCL_LO];                     // R18
        end
        if (match) begin
          buf_q[i] <= {dch_q[i], dcl_q[i]};                    // R11 R14
        end
      end
    end
  end

  // Output state; postscaler does not enter here
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NCH; i++) begin
      if (rst_i) begin
        out_q[i] <= 1'b0;
      end else if (cfg_q[i].enable & ~sleep_i) begin           // R19 R27
        if (match) begin
          out_q[i] <= ({dch_q[i], dcl_q[i]} != 10'h000);       // R08 R14
        end else if (hit[i]) begin
          out_q[i] <= 1'b0;                                    // R09 R17
        end
      end
    end
  end

  // Read mux and acknowledge
  logic [7:0] ch_rd;
  logic [7:0] rd_byte;

  assign ch_rd = (ch_sub == `SUB_CON) ?
                   {cfg_q[ch_idx].enable, cfg_q[ch_idx].oe,
                    val[ch_idx], cfg_q[ch_idx].pol, 4'h0} :   // R27
                 (ch_sub == `SUB_DCH) ? dch_q[ch_idx] :
                 (ch_sub == `SUB_DCL) ? {dcl_q[ch_idx], 6'h00} :
                 8'h00;
  assign rd_byte = sel_ctl  ? {1'b0, ctl_q} :
                   sel_cnt  ? cnt_q :
                   sel_per  ? per_q :
                   sel_flag ? {7'h00, flag_q} :
                   sel_ie   ? {7'h00, ie_q} :
                   sel_ch   ? ch_rd :
                   8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req;
      if (req) begin
        dat_q <= {24'h000000, rd_byte};
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_match_clears_count: assert property ( // R23
    match && !wr_cnt |=> cnt_q == 8'h00)
    else $error("count not cleared after match");

  a_post_sets_flag: assert property ( // R01
    match && post_q == ctl_q.post |=> flag_q)
    else $error("postscaler terminal did not set flag");

  a_flag_latched: assert property ( // R02
    flag_q && !wr_flag |=> flag_q)
    else $error("flag dropped without a clear");

  a_irq_gated: assert property ( // R02
    irq_o |-> ie_q && flag_q)
    else $error("interrupt without enable");

  a_sleep_holds: assert property ( // R05
    sleep_i && !wr_cnt && !wr_per |=> $stable(cnt_q) && $stable(per_q))
    else $error("timer moved during sleep");

  a_restart_sets: assert property ( // R08
    match && cfg_q[0].enable && !sleep_i &&
    {dch_q[0], dcl_q[0]} != 10'h000 |=> out_q[0] ##1 1'b1)
    else $error("output not set at period start");

  a_duty_clears: assert property ( // R09
    cfg_q[0].enable && run && !match && !wr_ctl && !wr_cnt &&
    !full[0] && tb_nx == buf_q[0] |=> !out_q[0] && tb == buf_q[0])
    else $error("output not cleared at duty");

  a_count_held: assert property ( // R26
    !ctl_q.on && !wr_cnt |=> $stable(cnt_q))
    else $error("count moved while timer off");

  a_sleep_outputs: assert property ( // R19
    sleep_i |=> $stable(out_q))
    else $error("channel output moved during sleep");

  a_tick_spacing: assert property ( // R06
    tick |=> (!tick) [*3])
    else $error("prescaled ticks closer than four clocks");

  a_buffer_load: assert property ( // R11
    match |=> buf_q[0] == {$past(dch_q[0]), $past(dcl_q[0])})
    else $error("duty buffer not loaded on match");

  a_scaler_clear: assert property ( // R25
    wr_ctl || wr_cnt |=> pc_q == 6'h00 && post_q == 4'h0)
    else $error("scalers not cleared by write");

  c_flag_set: cover property (post_hit ##1 flag_q);
  c_pwm_cycle: cover property (match ##[1:300] hit[0]);
  c_post_max: cover property (post_hit && ctl_q.post == 4'hF);

  // Per-channel checks
  for (genvar g = 0; g < NCH; g++) begin : g_chk
    a_full_duty: assert property (@(posedge clk_i) disable iff (rst_i) // R10
      out_q[g] && full[g] && !match |=> out_q[g])
      else $error("full duty output cleared");

    a_zero_duty: assert property (@(posedge clk_i) disable iff (rst_i) // R14
      match && cfg_q[g].enable && {dch_q[g], dcl_q[g]} == 10'h000
      |=> !out_q[g])
      else $error("zero duty output was set");

    c_full_duty: cover property (@(posedge clk_i) match && full[g]);
  end
endmodule

// File: verif/pin_model.sv
// Port pins seen from outside: driven level or a restless floating line
`timescale 1ns/1ps
module pin_model #(
  parameter int NCH = 4
) (
  // Clock
  input  wire logic           clk_i,
  // Pin drivers from the block
  input  wire logic [NCH-1:0] pin_i,
  input  wire logic [NCH-1:0] oe_i,
  // Resolved pin level
  output logic      [NCH-1:0] lvl_o
);
  logic [NCH-1:0] last_q = '0;
  // A released pin flips every cycle so a stale value never reads as valid
  assign lvl_o = (oe_i & pin_i) | (~oe_i & ~last_q);
  always_ff @(posedge clk_i) begin
    last_q <= lvl_o;
  end
endmodule

// File: verif/testbench.sv
// Self-checking bench for the timer and PWM block
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: %0h vs %0h", $time, a, b); end end
module testbench;
  logic        clk, rst, slp, cyc, we, ack, irq, mt;
  logic [7:0]  adr;
  logic [31:0] dw, dr, rv, kept;
  logic [3:0]  pwm, pin, oe, lvl, pn;
  int          fails, cmp_count, hi[4], m, n;
  int          pc[4] = '{0, 1, 7, 15};

  timebase_postscaler_pwm i_dut (
    .clk_i(clk), .rst_i(rst), .sleep_i(slp), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dw),
    .wb_sel_i(4'hF), .wb_dat_o(dr), .wb_ack_o(ack), .irq_o(irq),
    .match_o(mt), .pwm_o(pwm), .pin_o(pin), .pin_oe_o(oe));
  pin_model i_pins (.clk_i(clk), .pin_i(pin), .oe_i(oe), .lvl_o(lvl));

  task automatic xf(input logic w, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dw  <= {24'h000000, d};
    do @(posedge clk); while (ack !== 1'b1);
    rv = dr;
    cyc <= 1'b0;
  endtask

  task automatic chs(input logic [7:0] b, input logic [7:0] con,
                     input logic [9:0] d);
    xf(1'b1, b, con);
    xf(1'b1, b + 8'h04, d[9:2]);
    xf(1'b1, b + 8'h08, {d[1:0], 6'h00});
  endtask

  task automatic meas(input int k);
    hi = '{0, 0, 0, 0};
    m = 0;
    repeat (k) begin
      @(posedge clk);
      for (int c = 0; c < 4; c++) hi[c] += pwm[c];
      m += mt;
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    slp = 1'b0;
    cyc = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dw = 32'h00000000;
    fails = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    xf(1'b0, 8'h08, 8'h00);
    `CHK(rv, 32'h000000FF)
    xf(1'b0, 8'h00, 8'h00);
    `CHK(rv, 32'h00000000)
    xf(1'b0, 8'h0C, 8'h00);
    `CHK(rv, 32'h00000000)
    `CHK(oe, 4'h0)
    $display("test reset done");
    // Period of 16 clocks; duty 6, 0%, boundary 16, inverted 6
    xf(1'b1, 8'h08, 8'h03);
    chs(8'h40, 8'hC0, 10'h006);
    chs(8'h50, 8'hC0, 10'h000);
    chs(8'h60, 8'hC0, 10'h010);
    chs(8'h70, 8'hD0, 10'h006);
    xf(1'b1, 8'h00, 8'h04);
    meas(40);
    meas(64);
    `CHK(hi[0], 24)
    `CHK(hi[1], 0)
    `CHK(hi[2], 64)
    `CHK(hi[3], 40)
    `CHK(m, 4)
    `CHK(lvl, pin)
    $display("test waveform done");
    for (int p = 0; p < 3; p++) begin
      xf(1'b1, 8'h00, 8'(4 + p));
      meas(600);
      meas(1024);
      `CHK(m, 64 >> (2 * p))
      `CHK(hi[0], 384)
    end
    $display("test prescale done");
    xf(1'b1, 8'h10, 8'h01);
    for (int i = 0; i < 4; i++) begin
      xf(1'b1, 8'h00, 8'h00);
      xf(1'b1, 8'h0C, 8'h00);
      `CHK(irq, 1'b0)
      xf(1'b1, 8'h00, 8'(pc[i] * 8 + 4));
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
        @(posedge clk);
        n++;
      end
      `CHK(n >= 16 * pc[i] && n <= 16 * pc[i] + 20, 1'b1)
    end
    meas(64);
    `CHK(hi[0], 24)
    xf(1'b1, 8'h10, 8'h00);
    `CHK(irq, 1'b0)
    xf(1'b0, 8'h0C, 8'h00);
    `CHK(rv[0], 1'b1)
    $display("test postscale done");
    xf(1'b1, 8'h40, 8'h80);
    meas(64);
    `CHK(oe[0], 1'b0)
    `CHK(hi[0], 24)
    $display("test release done");
    slp <= 1'b1;
    xf(1'b0, 8'h04, 8'h00);
    kept = rv;
    pn = pin;
    meas(50);
    `CHK(m, 0)
    `CHK(pin, pn)
    xf(1'b0, 8'h04, 8'h00);
    `CHK(rv, kept)
    xf(1'b0, 8'h40, 8'h00);
    `CHK(rv[5], pwm[0])
    slp <= 1'b0;
    meas(64);
    `CHK(m, 4)
    $display("test sleep done");
    xf(1'b1, 8'h00, 8'h00);
    meas(64);
    `CHK(m, 0)
    $display("test stop done");
    xf(1'b1, 8'h00, 8'h04);
    meas(20);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    `CHK(oe, 4'h0)
    xf(1'b0, 8'h08, 8'h00);
    `CHK(rv, 32'h000000FF)
    xf(1'b0, 8'h70, 8'h00);
    `CHK(rv, 32'h00000000)
    $display("test second reset done");
    close_out();
  end
endmodule
